// File: logic/gateway_pkg.sv
package gateway_pkg;

    // Word address width for the host data-memory start word.
    localparam int ADDR_W = 14;
    // Width of one variable type code.
    localparam int VAR_W = 8;

    // Start word of each region selected by region pins {10,9}.
    localparam logic [ADDR_W-1:0] REGION0_BASE = 14'h0000;
    localparam logic [ADDR_W-1:0] REGION_P9_BASE = 14'h09C4;
    localparam logic [ADDR_W-1:0] REGION_P10_BASE = 14'h1388;
    localparam logic [ADDR_W-1:0] REGION_BOTH_BASE = 14'h1D4C;
    // Words between rotary steps.
    localparam logic [ADDR_W-1:0] ROTARY_STEP = 14'h0064;

    // Line-mode switch codes, pole 1 in bit 0.
    localparam logic [3:0] LM_422_CODE = 4'h4;
    localparam logic [3:0] LM_485_CODE = 4'hB;
    localparam logic [3:0] LM_CONFLICT_MASK = 4'hC;

    // First field protocol command groups and variable layout.
    localparam logic [2:0] NUM_GROUPS = 3'h5;
    localparam logic [VAR_W-1:0] SEG_TEMP_BASE = 8'h00;
    localparam logic [VAR_W-1:0] SEG_METER_BASE = 8'h80;

    // Registration list indexes.
    localparam logic LIST_WRITE = 1'b0;
    localparam logic LIST_READ = 1'b1;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } seq_state_type;

    // Decoded configuration held from reset to reset.
    typedef struct packed {
        logic [ADDR_W-1:0] start_word;
        logic              mode_485;
        logic              drive_422;
        logic              drive_485;
        logic              switch_error;
    } cfg_type;

    // One transfer order handed to the field link.
    typedef struct packed {
        logic             is_write;
        logic [VAR_W-1:0] var_code;
    } xfer_item_type;

endpackage

// File: logic/item_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module item_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;
    logic             push;
    logic             pop;

    // Full when pointers differ only in the wrap bit.
    assign in_ready = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                        (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
    assign out_valid = (wr_ptr_ff != rd_ptr_ff);
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;
    assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

    // Storage is written only on an accepted push.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    // Pointer update.
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// File: logic/serial_gateway_config_decode.sv
// Function
// - Repeat reads while read bit set, writes while write bit set; clearing stops.
// - Settings and data pass through host data memory over a serial link.
// - First protocol transfers the one selected command group of five.
// - First protocol sends different variable sets for controllers and meters.
// - Second protocol moves only registered variables, nothing else.
// - Registrations live in separate write and read lists.
// - Field port is either RS-422 or RS-485, never both driven.
// - Poles OFF,OFF,ON,OFF pick RS-422; ON,ON,OFF,ON pick RS-485.
// - Factory default switch position gives two-wire RS-485.
// - Start word combines the two region pins with the rotary value.
// - Both pins off: start word 0 plus 100 per rotary step.
// - Pin 9 off, pin 10 on: start word 5000 plus 100 per step.
// - Pin 9 on, pin 10 off: start word 2500 plus 100 per step.
// - Both pins on: start word 7500 plus 100 per step.
`timescale 1ns/1ps
`default_nettype none

module serial_gateway_config_decode
    import gateway_pkg::*;
#(
    parameter int LIST_DEPTH = 12,
    parameter int VARS_PER_GROUP = 4,
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [3:0]       line_mode_switch,
    input  wire logic [3:0]       start_word_rotary,
    input  wire logic             region_pin9,
    input  wire logic             region_pin10,
    input  wire logic             read_cmd,
    input  wire logic             write_cmd,
    input  wire logic             second_protocol_sel,
    input  wire logic             meter_segment,
    input  wire logic [2:0]       command_group,
    input  wire logic             reg_we,
    input  wire logic             reg_list,
    input  wire logic [VAR_W-1:0] reg_var_type,
    input  wire logic             reg_clear,
    output logic                  reg_refused_ff,
    output cfg_type               cfg_ff,
    output logic                  cfg_valid_ff,
    output logic                  group_error,
    output logic [3:0]            write_count,
    output logic [3:0]            read_count,
    output logic                  busy,
    output logic                  xfer_valid,
    input  wire logic             xfer_ready,
    output xfer_item_type         xfer_item
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    localparam int IW = 4;

    logic [VAR_W-1:0]  list_ff [2][LIST_DEPTH];
    logic [IW-1:0]     count_ff [2];
    seq_state_type     state_ff;
    seq_state_type     nxt_state;
    logic [IW-1:0]     idx_ff;
    logic              last_write_ff;
    logic              group_ok;
    logic              cur_write;
    logic [IW-1:0]     cur_len;
    logic              cur_cmd;
    logic              rd_go;
    logic              wr_go;
    logic              push_valid;
    logic              push_ready;
    logic              push_last;
    xfer_item_type     push_item;
    logic [ADDR_W-1:0] region_base;

    ////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Length of one pass for the chosen direction.
    function automatic logic [IW-1:0] pass_len(input logic w, input logic second,
                                               input logic grp_ok,
                                               input logic [IW-1:0] wr_n,
                                               input logic [IW-1:0] rd_n);
        logic [IW-1:0] n;
        n = '0;
        if (second) begin
            n = w ? wr_n : rd_n;
        end else if (grp_ok) begin
            n = IW'(VARS_PER_GROUP);
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration capture.

    // Region base chosen by pins {10,9}.
    always_comb begin
        unique case ({region_pin10, region_pin9})
            2'b00: region_base = REGION0_BASE;
            2'b10: region_base = REGION_P10_BASE;
            2'b01: region_base = REGION_P9_BASE;
            2'b11: region_base = REGION_BOTH_BASE;
        endcase
    end

    // Switches are taken on the first enabled edge after reset and then held.
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_valid_ff <= 1'b0;
            cfg_ff <= '0;
        end else if (ce && !cfg_valid_ff) begin
            cfg_valid_ff <= 1'b1;
            cfg_ff.start_word <= region_base +
                (ADDR_W'(start_word_rotary) * ROTARY_STEP);
            cfg_ff.mode_485 <= (line_mode_switch != LM_422_CODE);
            // Poles 3 and 4 together shorts the drivers, so neither is enabled.
            if ((line_mode_switch & LM_CONFLICT_MASK) == LM_CONFLICT_MASK) begin
                cfg_ff.drive_422 <= 1'b0;
                cfg_ff.drive_485 <= 1'b0;
                cfg_ff.switch_error <= 1'b1;
            end else begin
                cfg_ff.drive_422 <= (line_mode_switch == LM_422_CODE);
                cfg_ff.drive_485 <= (line_mode_switch != LM_422_CODE);
                cfg_ff.switch_error <= (line_mode_switch != LM_422_CODE) &&
                                       (line_mode_switch != LM_485_CODE);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registration lists, one per direction.

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_list
            // Append on a write to this list; clear empties both lists.
            always_ff @(posedge clk) begin
                if (rst) begin
                    count_ff[g] <= '0;
                end else if (ce) begin
                    if (reg_clear) begin
                        count_ff[g] <= '0;
                    end else if (reg_we && (reg_list == 1'(g)) &&
                                 (count_ff[g] < IW'(LIST_DEPTH))) begin
                        list_ff[g][count_ff[g]] <= reg_var_type;
                        count_ff[g] <= count_ff[g] + 1'b1;
                    end
                end
            end
        end
    endgenerate

    // A registration beyond the list depth is dropped and flagged until clear.
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_refused_ff <= 1'b0;
        end else if (ce) begin
            if (reg_we && (count_ff[reg_list] >= IW'(LIST_DEPTH))) begin
                reg_refused_ff <= 1'b1;
            end else if (reg_clear) begin
                reg_refused_ff <= 1'b0;
            end
        end
    end

    assign write_count = count_ff[LIST_WRITE];
    assign read_count = count_ff[LIST_READ];

    ////////////////////////////////////////////////////////////////////////////
    // Cyclic transfer sequencer.

    assign group_ok = (command_group < NUM_GROUPS);
    assign group_error = !second_protocol_sel && !group_ok;
    assign rd_go = read_cmd && cfg_valid_ff && !cfg_ff.switch_error &&
                   (pass_len(1'b0, second_protocol_sel, group_ok,
                             write_count, read_count) != '0);
    assign wr_go = write_cmd && cfg_valid_ff && !cfg_ff.switch_error &&
                   (pass_len(1'b1, second_protocol_sel, group_ok,
                             write_count, read_count) != '0);

    assign cur_write = (state_ff == ST_WRITE);
    assign cur_cmd = cur_write ? wr_go : rd_go;
    assign cur_len = pass_len(cur_write, second_protocol_sel, group_ok,
                              write_count, read_count);
    assign push_valid = (state_ff != ST_IDLE) && cur_cmd && (idx_ff < cur_len);
    assign push_last = (idx_ff == cur_len - 1'b1);
    assign busy = (state_ff != ST_IDLE);

    // Item contents: registered type or group table entry per segment type.
    always_comb begin
        push_item.is_write = cur_write;
        if (second_protocol_sel) begin
            push_item.var_code = list_ff[cur_write ? 1'b0 : 1'b1][idx_ff];
        end else begin
            push_item.var_code = (meter_segment ? SEG_METER_BASE : SEG_TEMP_BASE) +
                VAR_W'(command_group) * VAR_W'(VARS_PER_GROUP) +
                VAR_W'(idx_ff);
        end
    end

    // Next state: alternate read and write passes while both bits stand.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (rd_go && (!wr_go || last_write_ff)) begin
                    nxt_state = ST_READ;
                end else if (wr_go) begin
                    nxt_state = ST_WRITE;
                end
            end
            ST_READ, ST_WRITE: begin
                if (!push_valid || (push_ready && push_last)) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // Index walks one item per accepted push and restarts each pass.
    always_ff @(posedge clk) begin
        if (rst) begin
            idx_ff <= '0;
        end else if (ce) begin
            if (nxt_state == ST_IDLE || state_ff == ST_IDLE) begin
                idx_ff <= '0;
            end else if (push_valid && push_ready) begin
                idx_ff <= idx_ff + 1'b1;
            end
        end
    end

    // Remembers the last direction so neither starves the other.
    always_ff @(posedge clk) begin
        if (rst) begin
            last_write_ff <= 1'b0;
        end else if (ce && state_ff != ST_IDLE && nxt_state == ST_IDLE) begin
            last_write_ff <= cur_write;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Order buffer toward the field link; a stalled link stalls the sequencer.

    item_fifo #(
        .WIDTH ($bits(xfer_item_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_item),
        .out_valid (xfer_valid),
        .out_ready (xfer_ready),
        .out_data  (xfer_item)
    );

endmodule

`default_nettype wire

// File: dv/xfer_sink.sv
`timescale 1ns/1ps
`default_nettype none

module xfer_sink
    import gateway_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          stall,
    input  wire logic          slow,
    input  wire logic          xfer_valid,
    input  wire xfer_item_type xfer_item,
    output logic               xfer_ready
);
    xfer_item_type got[$];

    // Ready moves only after an edge; slow mode accepts every other cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            xfer_ready <= 1'b0;
        end else begin
            xfer_ready <= !stall && (!slow || !xfer_ready);
        end
    end

    // Every accepted item is logged in arrival order for the bench.
    always @(posedge clk) begin
        if (!rst && xfer_valid && xfer_ready) begin
            got.push_back(xfer_item);
        end
    end
endmodule

`default_nettype wire

// File: dv/serial_gateway_props.sv
`timescale 1ns/1ps
`default_nettype none

module serial_gateway_props
    import gateway_pkg::*;
#(
    parameter int LIST_DEPTH = 12
) (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic          ce,
    input wire logic [3:0]    line_mode_switch,
    input wire logic [3:0]    start_word_rotary,
    input wire logic          region_pin9,
    input wire logic          region_pin10,
    input wire logic          read_cmd,
    input wire logic          write_cmd,
    input wire logic          second_protocol_sel,
    input wire logic [2:0]    command_group,
    input wire logic          reg_we,
    input wire logic          reg_list,
    input wire logic          reg_clear,
    input wire logic          reg_refused_ff,
    input wire cfg_type       cfg_ff,
    input wire logic          cfg_valid_ff,
    input wire logic          group_error,
    input wire logic [3:0]    read_count,
    input wire logic          busy,
    input wire logic          xfer_valid,
    input wire logic          xfer_ready,
    input wire xfer_item_type xfer_item
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Region base word picked by pins {10,9}.
    function automatic logic [13:0] base_of(input logic [1:0] p);
        case (p)
            2'h1:    base_of = 14'h09C4;
            2'h2:    base_of = 14'h1388;
            2'h3:    base_of = 14'h1D4C;
            default: base_of = 14'h0000;
        endcase
    endfunction

    sequence s_cap;
        $rose(cfg_valid_ff);
    endsequence
    sequence s_read_ready;
        ce && read_cmd && cfg_valid_ff && !cfg_ff.switch_error && !second_protocol_sel
            && !group_error;
    endsequence

    AST_START_WORD: assert property (
        s_cap |-> cfg_ff.start_word == base_of($past({region_pin10, region_pin9}))
            + 14'h0064 * $past(start_word_rotary)
    ) else $error("start word wrong");
    AST_MODE_422: assert property (
        s_cap ##0 ($past(line_mode_switch) == LM_422_CODE) |-> cfg_ff.drive_422
            && !cfg_ff.drive_485 && !cfg_ff.mode_485 && !cfg_ff.switch_error
    ) else $error("rs422 decode wrong");
    AST_MODE_485: assert property (
        s_cap ##0 ($past(line_mode_switch) == LM_485_CODE) |-> cfg_ff.drive_485
            && cfg_ff.mode_485 && !cfg_ff.drive_422 && !cfg_ff.switch_error
    ) else $error("rs485 decode wrong");
    AST_POLE_CONFLICT: assert property (
        s_cap ##0 (($past(line_mode_switch) & LM_CONFLICT_MASK) == LM_CONFLICT_MASK)
            |-> !cfg_ff.drive_422 && !cfg_ff.drive_485 && cfg_ff.switch_error
    ) else $error("pole conflict not blocked");
    AST_ONE_MODE: assert property (!(cfg_ff.drive_422 && cfg_ff.drive_485))
        else $error("both line drivers on");
    AST_CFG_HOLD: assert property (cfg_valid_ff |=> cfg_valid_ff && $stable(cfg_ff))
        else $error("config changed");
    AST_GROUP_ERR: assert property (
        group_error == (!second_protocol_sel && command_group > 3'h4)
    ) else $error("group error wrong");
    AST_READ_APPEND: assert property (
        ce && reg_we && !reg_clear && reg_list == LIST_READ && read_count < LIST_DEPTH
            |=> read_count == $past(read_count) + 4'h1
    ) else $error("read list not grown");
    AST_LIST_FULL: assert property (
        ce && reg_we && !reg_clear && reg_list == LIST_READ && read_count == LIST_DEPTH
            |=> reg_refused_ff && read_count == $past(read_count)
    ) else $error("full list not refused");
    AST_ITEM_HOLD: assert property (xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_item))
        else $error("item dropped while stalled");
    AST_CMD_STOP: assert property (ce && !read_cmd && !write_cmd |=> !busy)
        else $error("pass runs without command");
    AST_CYCLIC_READ: assert property (s_read_ready [*2] |-> busy || $past(busy))
        else $error("read cycle not repeated");
endmodule

bind serial_gateway_config_decode serial_gateway_props #(.LIST_DEPTH(LIST_DEPTH)) i_props (
    .clk(clk), .rst(rst), .ce(ce), .line_mode_switch(line_mode_switch),
    .start_word_rotary(start_word_rotary), .region_pin9(region_pin9),
    .region_pin10(region_pin10), .read_cmd(read_cmd), .write_cmd(write_cmd),
    .second_protocol_sel(second_protocol_sel), .command_group(command_group),
    .reg_we(reg_we), .reg_list(reg_list), .reg_clear(reg_clear),
    .reg_refused_ff(reg_refused_ff), .cfg_ff(cfg_ff), .cfg_valid_ff(cfg_valid_ff),
    .group_error(group_error), .read_count(read_count), .busy(busy),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_item(xfer_item));

`default_nettype wire

// File: dv/tb_serial_gateway_config_decode.sv
`timescale 1ns/1ps
`default_nettype none

module tb_serial_gateway_config_decode;
    import gateway_pkg::*;
    logic clk, rst, ce, region_pin9, region_pin10, read_cmd, write_cmd, stall, slow;
    logic second_protocol_sel, meter_segment, reg_we, reg_list, reg_clear;
    logic reg_refused_ff, cfg_valid_ff, group_error, busy, xfer_valid, xfer_ready;
    logic [3:0] line_mode_switch, start_word_rotary, write_count, read_count;
    logic [2:0] command_group;
    logic [7:0] reg_var_type;
    cfg_type       cfg_ff;
    xfer_item_type xfer_item;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;

    serial_gateway_config_decode i_dut (
        .clk(clk), .rst(rst), .ce(ce), .line_mode_switch(line_mode_switch),
        .start_word_rotary(start_word_rotary), .region_pin9(region_pin9),
        .region_pin10(region_pin10), .read_cmd(read_cmd), .write_cmd(write_cmd),
        .second_protocol_sel(second_protocol_sel), .meter_segment(meter_segment),
        .command_group(command_group), .reg_we(reg_we), .reg_list(reg_list),
        .reg_var_type(reg_var_type), .reg_clear(reg_clear), .reg_refused_ff(reg_refused_ff),
        .cfg_ff(cfg_ff), .cfg_valid_ff(cfg_valid_ff), .group_error(group_error),
        .write_count(write_count), .read_count(read_count), .busy(busy),
        .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_item(xfer_item));
    xfer_sink i_sink (.clk(clk), .rst(rst), .stall(stall), .slow(slow),
        .xfer_valid(xfer_valid), .xfer_item(xfer_item), .xfer_ready(xfer_ready));

    // Free-running 250 MHz clock.
    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Counts every comparison and reports mismatches at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end

    // Resets with given switches, checks the decode, then checks it holds.
    task automatic do_cfg(input logic [3:0] lm, input logic [3:0] rot, input logic [1:0] rp,
                          input logic [3:0] mode);
        logic [13:0] word;
        word = (rp[1] ? (rp[0] ? 14'h1D4C : 14'h1388) : (rp[0] ? 14'h09C4 : 14'h0000))
            + 14'h0064 * rot;
        @(negedge clk);
        rst = 1'b1;
        line_mode_switch = lm;
        start_word_rotary = rot;
        {region_pin10, region_pin9} = rp;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk(cfg_ff.start_word, word);
        chk(cfg_ff[3:0], mode);
        line_mode_switch = ~lm;
        start_word_rotary = ~rot;
        {region_pin10, region_pin9} = ~rp;
        repeat (3) @(negedge clk);
        chk({cfg_valid_ff, cfg_ff.start_word, cfg_ff[3:0]}, {1'b1, word, mode});
    endtask

    // Drains the stream after commands are dropped.
    task automatic drain();
        for (int n = 0; n < 200 && (busy || xfer_valid); n++) @(negedge clk);
    endtask

    // First protocol: one group per pass, set chosen by instrument type.
    task automatic run_first(input logic met, input logic [2:0] grp);
        i_sink.got.delete();
        @(negedge clk);
        second_protocol_sel = 1'b0;
        meter_segment = met;
        command_group = grp;
        slow = met;
        read_cmd = 1'b1;
        for (int n = 0; n < 200 && i_sink.got.size() < 8; n++) @(negedge clk);
        chk(group_error, grp > 3'h4);
        read_cmd = 1'b0;
        drain();
        chk(i_sink.got.size() >= 8, grp < 3'h5);
        foreach (i_sink.got[k])
            chk(i_sink.got[k], {1'b0, (met ? 8'h80 : 8'h00) + {3'h0, grp, 2'h0} + 8'(k % 4)});
    endtask

    // Appends one variable code to a list; the caller lowers the strobe after the last one.
    task automatic reg_add(input logic lst, input logic [7:0] v);
        reg_list = lst;
        reg_var_type = v;
        reg_we = 1'b1;
        @(negedge clk);
    endtask

    // Second protocol: only listed codes move, in list order, through a stalled buffer.
    task automatic run_second();
        logic [7:0] wl[2] = '{8'h11, 8'h22};
        logic [7:0] rl[3] = '{8'h31, 8'h32, 8'h33};
        int wi = 0;
        int ri = 0;
        reg_clear = 1'b1;
        @(negedge clk);
        reg_clear = 1'b0;
        foreach (wl[k]) reg_add(LIST_WRITE, wl[k]);
        foreach (rl[k]) reg_add(LIST_READ, rl[k]);
        reg_we = 1'b0;
        chk({write_count, read_count}, 8'h23);
        i_sink.got.delete();
        stall = 1'b1;
        slow = 1'b0;
        second_protocol_sel = 1'b1;
        read_cmd = 1'b1;
        write_cmd = 1'b1;
        repeat (80) @(negedge clk);
        chk({i_sink.got.size() == 0, xfer_valid, busy}, 3'h7);
        stall = 1'b0;
        for (int n = 0; n < 400 && i_sink.got.size() < 40; n++) @(negedge clk);
        read_cmd = 1'b0;
        write_cmd = 1'b0;
        drain();
        foreach (i_sink.got[k]) begin
            if (i_sink.got[k].is_write) begin
                chk(i_sink.got[k].var_code, wl[wi % 2]);
                wi++;
            end else begin
                chk(i_sink.got[k].var_code, rl[ri % 3]);
                ri++;
            end
        end
        chk(wi > 0 && ri > 0, 1);
        for (int n = 0; n < 10; n++) reg_add(LIST_READ, 8'h40 + 8'(n));
        reg_we = 1'b0;
        chk({reg_refused_ff, read_count}, 5'h1C);
        // A registration while the clock enable is low must leave the lists frozen.
        ce = 1'b0;
        reg_add(LIST_WRITE, 8'h55);
        reg_we = 1'b0;
        ce = 1'b1;
        chk({reg_refused_ff, write_count}, 5'h12);
        reg_clear = 1'b1;
        @(negedge clk);
        reg_clear = 1'b0;
        @(negedge clk);
        chk({reg_refused_ff, write_count, read_count}, 9'h000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        {region_pin9, region_pin10, read_cmd, write_cmd, stall, slow} = 6'h00;
        {second_protocol_sel, meter_segment, reg_we, reg_list, reg_clear} = 5'h00;
        {line_mode_switch, start_word_rotary, command_group, reg_var_type} = 19'h00000;
        for (int r = 0; r < 8; r++) do_cfg(4'hB, r[0] ? 4'hF : 4'h0, 2'(r >> 1), 4'hA);
        do_cfg(4'h4, 4'h1, 2'h0, 4'h4);
        do_cfg(4'hC, 4'h7, 2'h2, 4'h9);
        do_cfg(4'hB, 4'h3, 2'h1, 4'hA);
        for (int g = 0; g < 6; g++) begin
            run_first(1'b0, 3'(g));
            run_first(1'b1, 3'(g));
        end
        run_second();
        conclude();
    end
endmodule

`default_nettype wire
